// >>> hw/flash_self_program_sequencer.sv
// flash self-programming sequencer with apb register access
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps

module flash_self_program_sequencer
  import self_prog_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = PROG_MIN_CYC
) (
  // clock and reset
  input  wire logic                 CLK_SYS,
  input  wire logic                 SYS_RST,
  // apb slave
  input  wire logic                 PSEL,
  input  wire logic                 PENABLE,
  input  wire logic                 PWRITE,
  input  wire logic [ADDR_W-1:0]    PADDR,
  input  wire logic [31:0]          PWDATA,
  output logic                      PREADY,
  output logic [31:0]               PRDATA,
  output logic                      PSLVERR,
  // fuse and eeprom status
  input  wire logic                 BOOT_RST_FUSE,
  input  wire logic                 EE_WRITE,
  // cpu side
  output logic [14:0]               RESET_VECTOR,
  output logic                      CPU_HALT,
  output logic                      RWW_READ_BLOCK,
  output logic                      READY_IRQ,
  output logic [14:0]               LOAD_WORD_ADDR,
  output logic                      LOAD_HI_BYTE,
  // flash array side
  output logic                      FLASH_ERASE,
  output logic                      FLASH_WRITE,
  output logic [PAGE_BITS-1:0]      FLASH_PAGE,
  input  wire logic [WORD_BITS-1:0] FLASH_BUF_IDX,
  output logic [15:0]               FLASH_BUF_DATA,
  output logic                      LOCK_WRITE,
  output logic [7:0]                LOCK_DATA
);

  localparam int CNT_W = $clog2(PROG_CYCLES + 1);

  // ****************************************
  // state
  // ****************************************
  state_type              state_r;
  kind_type               kind_r;
  logic [2:0]             arm_cnt_r;
  logic [CNT_W-1:0]       prog_cnt_r;
  logic [7:0]             ptr_lo_r;
  logic [7:0]             ptr_hi_r;
  logic [15:0]            data_r;
  logic                   ie_r;
  logic                   busy_r;
  logic [PAGE_BITS-1:0]   page_r;
  logic [PAGE_WORDS-1:0]  loaded_r;
  logic [15:0]            buf_r [PAGE_WORDS];
  logic                   pready_r;
  logic [31:0]            prdata_r;
  logic                   pslverr_r;
  logic [14:0]            vector_r;
  logic                   halt_r;
  logic                   irq_r;
  logic [14:0]            ld_addr_r;
  logic                   ld_hi_r;
  logic                   erase_r;
  logic                   write_r;
  logic [15:0]            buf_out_r;
  logic                   lock_wr_r;
  logic [7:0]             lock_data_r;

  // ****************************************
  // apb decode
  // ****************************************
  wire                 setup     = PSEL & ~PENABLE;
  wire                 wr_done   = PSEL & PENABLE & pready_r & PWRITE;
  wire                 hit_ctrl  = PADDR == OFS_CTRL;
  wire                 hit_lo    = PADDR == OFS_PTR_LO;
  wire                 hit_hi    = PADDR == OFS_PTR_HI;
  wire                 hit_data  = PADDR == OFS_DATA;
  wire                 hit_store = PADDR == OFS_STORE;
  wire                 hit_vec   = PADDR == OFS_VECTOR;
  wire                 mapped    = hit_ctrl | hit_lo | hit_hi | hit_data
                                   | hit_store | hit_vec;
  wire [PTR_W-1:0]     pointer   = {ptr_hi_r, ptr_lo_r};
  wire [WORD_BITS-1:0] word_idx  = pointer[WORD_LSB +: WORD_BITS];
  wire [PAGE_BITS-1:0] page_idx  = pointer[PAGE_LSB +: PAGE_BITS];
  wire                 cmd_en    = state_r != ST_IDLE;
  wire [2:0]           armed     = state_r != ST_ARMED ? 3'h0 :
                                   kind_r == K_LOCK    ? 3'h4 :
                                   kind_r == K_WRITE   ? 3'h2 :
                                   kind_r == K_ERASE   ? 3'h1 : 3'h0;
  wire [7:0]           ctrl_rd   = {ie_r, busy_r, 2'b00, armed, cmd_en};
  wire [31:0]          rd_mux    = hit_ctrl ? {24'h000000, ctrl_rd} :
                                   hit_lo   ? {24'h000000, ptr_lo_r} :
                                   hit_hi   ? {24'h000000, ptr_hi_r} :
                                   hit_data ? {16'h0000, data_r} :
                                   hit_vec  ? {17'h00000, vector_r} : 32'h00000000;

  // ****************************************
  // command decode
  // ****************************************
  wire [5:0] code     = PWDATA[CMD_LSB +: CMD_W];
  wire       ctrl_wr  = wr_done & hit_ctrl & (state_r != ST_PROG) & ~EE_WRITE;
  wire       arm_ok   = (code == CODE_ERASE) | (code == CODE_LOAD)
                        | (code == CODE_WRITE) | (code == CODE_LOCK);
  wire       reen_wr  = ctrl_wr & (code == CODE_REEN);
  wire       store    = wr_done & hit_store & (state_r == ST_ARMED);
  wire       prog_go  = store & ((kind_r == K_ERASE) | (kind_r == K_WRITE));
  wire       prog_end = (state_r == ST_PROG)
                        & (prog_cnt_r == CNT_W'(PROG_CYCLES - 1));
  wire       buf_wr   = store & (kind_r == K_LOAD);
  wire       buf_clr  = SYS_RST | reen_wr | EE_WRITE
                        | (prog_end & (kind_r == K_WRITE));
  wire       arm_end  = (state_r == ST_ARMED) & ~store
                        & (arm_cnt_r == 3'(ARM_CYCLES - 1));
  wire       in_no_read_while_write_section  = page_r >= NO_READ_WHILE_WRITE_SECTION_PAGE;

  // ****************************************
  // apb response
  // ****************************************
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= setup;
      prdata_r  <= setup & ~PWRITE ? rd_mux : 32'h00000000;
      pslverr_r <= setup & ~mapped;
    end
  end

  // ****************************************
  // software visible registers
  // ****************************************
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      ptr_lo_r <= 8'h00;
      ptr_hi_r <= 8'h00;
      data_r   <= 16'h0000;
      ie_r     <= CTRL_RESET[IE_BIT];
    end else begin
      if (wr_done & hit_lo)
        ptr_lo_r <= PWDATA[7:0];
      if (wr_done & hit_hi)
        ptr_hi_r <= PWDATA[7:0];
      if (wr_done & hit_data)
        data_r <= PWDATA[15:0];
      if (ctrl_wr)
        ie_r <= PWDATA[IE_BIT];
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      state_r    <= ST_IDLE;
      kind_r     <= K_LOAD;
      arm_cnt_r  <= 3'h0;
      prog_cnt_r <= '0;
      page_r     <= '0;
    end else begin
      unique case (state_r)
        ST_IDLE, ST_ARMED: begin
          arm_cnt_r <= arm_cnt_r + 3'h1;
          if (ctrl_wr & arm_ok) begin
            state_r   <= ST_ARMED;
            arm_cnt_r <= 3'h0;
            kind_r    <= code == CODE_ERASE ? K_ERASE :
                         code == CODE_WRITE ? K_WRITE :
                         code == CODE_LOCK  ? K_LOCK  : K_LOAD;
          end else if (ctrl_wr | arm_end) begin
            state_r <= ST_IDLE;
          end else if (prog_go) begin
            state_r    <= ST_PROG;
            prog_cnt_r <= '0;
            page_r     <= page_idx;
          end else if (store) begin
            state_r <= ST_IDLE;
          end
        end
        ST_PROG: begin
          prog_cnt_r <= prog_cnt_r + CNT_W'(1);
          if (prog_end)
            state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // section busy flag
  // ****************************************
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST)
      busy_r <= 1'b0;
    else if (prog_go)
      busy_r <= 1'b1;
    else if (reen_wr)
      busy_r <= 1'b0;
  end

  // ****************************************
  // temporary page buffer
  // ****************************************
  for (genvar g = 0; g < PAGE_WORDS; g++) begin : g_buf
    always_ff @(posedge CLK_SYS) begin
      if (buf_clr) begin
        loaded_r[g] <= 1'b0;
      end else if (buf_wr & (word_idx == WORD_BITS'(g)) & ~loaded_r[g]) begin
        loaded_r[g] <= 1'b1;
        buf_r[g]    <= data_r;
      end
    end
  end

  // ****************************************
  // output registers
  // ****************************************
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      vector_r    <= APP_VECTOR;
      halt_r      <= 1'b0;
      irq_r       <= 1'b0;
      ld_addr_r   <= 15'h0000;
      ld_hi_r     <= 1'b0;
      erase_r     <= 1'b0;
      write_r     <= 1'b0;
      buf_out_r   <= ERASED_WORD;
      lock_wr_r   <= 1'b0;
      lock_data_r <= 8'h00;
    end else begin
      vector_r    <= BOOT_RST_FUSE ? APP_VECTOR : BOOT_VECTOR;
      halt_r      <= (state_r == ST_PROG) & in_no_read_while_write_section;
      irq_r       <= ie_r & ~cmd_en;
      ld_addr_r   <= pointer[PTR_W-1:WORD_LSB];
      ld_hi_r     <= pointer[BYTE_SEL_BIT];
      erase_r     <= (state_r == ST_PROG) & (kind_r == K_ERASE);
      write_r     <= (state_r == ST_PROG) & (kind_r == K_WRITE);
      buf_out_r   <= loaded_r[FLASH_BUF_IDX] ? buf_r[FLASH_BUF_IDX] : ERASED_WORD;
      lock_wr_r   <= store & (kind_r == K_LOCK);
      lock_data_r <= data_r[7:0];
    end
  end

  assign PREADY         = pready_r;
  assign PRDATA         = prdata_r;
  assign PSLVERR        = pslverr_r;
  assign RESET_VECTOR   = vector_r;
  assign CPU_HALT       = halt_r;
  assign RWW_READ_BLOCK = busy_r;
  assign READY_IRQ      = irq_r;
  assign LOAD_WORD_ADDR = ld_addr_r;
  assign LOAD_HI_BYTE   = ld_hi_r;
  assign FLASH_ERASE    = erase_r;
  assign FLASH_WRITE    = write_r;
  assign FLASH_PAGE     = page_r;
  assign FLASH_BUF_DATA = buf_out_r;
  assign LOCK_WRITE     = lock_wr_r;
  assign LOCK_DATA      = lock_data_r;

endmodule

// >>> hw/self_prog_pkg.sv
// constants and types for the flash self-programming sequencer
package self_prog_pkg;

  // ****************************************
  // apb register map (byte addresses)
  // ****************************************
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_PTR_LO   = 8'h04;
  localparam logic [7:0]  OFS_PTR_HI   = 8'h08;
  localparam logic [7:0]  OFS_DATA     = 8'h0C;
  localparam logic [7:0]  OFS_STORE    = 8'h10;
  localparam logic [7:0]  OFS_VECTOR   = 8'h14;

  // ****************************************
  // control/status fields
  // ****************************************
  localparam int          CMD_LSB      = 0;
  localparam int          CMD_W        = 6;
  localparam int          BUSY_BIT     = 6;
  localparam int          IE_BIT       = 7;
  localparam logic [5:0]  CODE_ERASE   = 6'h03;
  localparam logic [5:0]  CODE_LOAD    = 6'h01;
  localparam logic [5:0]  CODE_WRITE   = 6'h05;
  localparam logic [5:0]  CODE_LOCK    = 6'h09;
  localparam logic [5:0]  CODE_REEN    = 6'h11;
  localparam logic [7:0]  CTRL_RESET   = 8'h00;

  // ****************************************
  // pointer layout
  // ****************************************
  localparam int          PTR_W        = 16;
  localparam int          BYTE_SEL_BIT = 0;
  localparam int          WORD_LSB     = 1;
  localparam int          WORD_BITS    = 6;
  localparam int          PAGE_WORDS   = 64;
  localparam int          PAGE_LSB     = WORD_LSB + WORD_BITS;
  localparam int          PAGE_BITS    = PTR_W - PAGE_LSB;
  localparam logic [15:0] ERASED_WORD  = 16'hFFFF;

  // ****************************************
  // reset vectors and first page of the no-read-while-write section
  // ****************************************
  localparam logic [14:0] APP_VECTOR   = 15'h0000;
  localparam logic [14:0] BOOT_VECTOR  = 15'h3C00;
  localparam logic [8:0]  NO_READ_WHILE_WRITE_SECTION_PAGE    = 9'h0E0;

  // ****************************************
  // timing
  // ****************************************
  localparam int          CLK_NS       = 50;
  localparam int          ARM_CYCLES   = 4;
  localparam int          PROG_MIN_NS  = 3700000;
  localparam int          PROG_MAX_NS  = 4500000;
  localparam int          PROG_MIN_CYC = (PROG_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int          PROG_MAX_CYC = PROG_MAX_NS / CLK_NS;

  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_PROG} state_type;
  typedef enum logic [1:0] {K_ERASE, K_LOAD, K_WRITE, K_LOCK} kind_type;

endpackage

// >>> bench/self_prog_sva.sv
// assertions for the self-programming sequencer
`timescale 1ns/100ps
module self_prog_checker
  import self_prog_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = 20
) (
  // clock, reset, bus
  input logic                 CLK_SYS,
  input logic                 SYS_RST,
  input logic                 PSEL,
  input logic                 PENABLE,
  input logic                 PREADY,
  input logic                 PSLVERR,
  // device side
  input logic                 BOOT_RST_FUSE,
  input logic [14:0]          RESET_VECTOR,
  input logic                 CPU_HALT,
  input logic                 RWW_READ_BLOCK,
  input logic                 FLASH_ERASE,
  input logic                 FLASH_WRITE,
  input logic [PAGE_BITS-1:0] FLASH_PAGE
);
  logic        op;
  logic [31:0] cnt_r;
  assign op = FLASH_ERASE | FLASH_WRITE;
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST || !op)
      cnt_r <= '0;
    else
      cnt_r <= cnt_r + 32'h1;
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  sequence s_setup; PSEL && !PENABLE; endsequence
  sequence s_answer; PSEL && PENABLE && PREADY; endsequence
  vec_select_a: assert property (!$past(SYS_RST) |-> RESET_VECTOR ==
    ($past(BOOT_RST_FUSE) ? APP_VECTOR : BOOT_VECTOR)) else $error("vector wrong");
  bus_answer_a: assert property (s_setup |=> s_answer) else $error("no ready");
  ready_pulse_a: assert property (PREADY |=> !PREADY) else $error("ready held");
  err_ready_a: assert property (PSLVERR |-> PREADY) else $error("error alone");
  cpu_halt_a: assert property (CPU_HALT == (op && FLASH_PAGE >= NO_READ_WHILE_WRITE_SECTION_PAGE))
    else $error("halt wrong");
  busy_block_a: assert property (op |-> RWW_READ_BLOCK) else $error("not blocked");
  one_op_a: assert property (!(FLASH_ERASE && FLASH_WRITE)) else $error("two ops");
  page_hold_a: assert property (op && $past(op) |-> $stable(FLASH_PAGE))
    else $error("page moved");
  op_length_a: assert property ($fell(op) |-> cnt_r == PROG_CYCLES)
    else $error("op length");
endmodule

// >>> bench/cpu_core_model.sv
// cpu core model issuing register and store accesses
`timescale 1ns/100ps
module cpu_core_model
  import self_prog_pkg::*;
(
  // clock
  input  logic              clk,
  // apb master
  output logic              psel,
  output logic              penable,
  output logic              pwrite,
  output logic [ADDR_W-1:0] paddr,
  output logic [31:0]       pwdata,
  input  logic              pready,
  input  logic [31:0]       prdata,
  input  logic              pslverr
);
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic spm(input logic [7:0] c, input int gap);
    logic [31:0] q;
    logic        e;
    xfer(1'b1, OFS_CTRL, {24'h0, c}, q, e);
    repeat (gap) @(posedge clk);
    xfer(1'b1, OFS_STORE, 32'h0, q, e);
  endtask
endmodule

// >>> bench/testbench.sv
// self-checking bench for the self-programming sequencer
`timescale 1ns/100ps
module testbench;
  import self_prog_pkg::*;
  localparam int unsigned PCYC = 20;
  logic        clk, rst, fuse, ee, psel, pen, pwr, prdy, perr, e;
  logic        halt, blk, irq, lhi, fer, fwr, lkw;
  logic [7:0]  lkd;
  logic [7:0]  padr;
  logic [31:0] pwd, prd, q;
  logic [14:0] vec, lwa;
  logic [8:0]  page;
  logic [5:0]  idx;
  logic [15:0] bdat;
  int          error_cnt = 0;
  int          cmp_count = 0;
  flash_self_program_sequencer #(.PROG_CYCLES(PCYC)) dut (
    .CLK_SYS(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(padr), .PWDATA(pwd), .PREADY(prdy), .PRDATA(prd), .PSLVERR(perr),
    .BOOT_RST_FUSE(fuse), .EE_WRITE(ee), .RESET_VECTOR(vec), .CPU_HALT(halt),
    .RWW_READ_BLOCK(blk), .READY_IRQ(irq), .LOAD_WORD_ADDR(lwa), .LOAD_HI_BYTE(lhi),
    .FLASH_ERASE(fer), .FLASH_WRITE(fwr), .FLASH_PAGE(page), .FLASH_BUF_IDX(idx),
    .FLASH_BUF_DATA(bdat), .LOCK_WRITE(lkw), .LOCK_DATA(lkd));
  cpu_core_model cpu (.clk(clk), .psel(psel), .penable(pen), .pwrite(pwr), .paddr(padr),
    .pwdata(pwd), .pready(prdy), .prdata(prd), .pslverr(perr));
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] a);
    cmp_count++;
    if (a !== x) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, x, a);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    cpu.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string n);
    cpu.xfer(1'b0, a, 32'h0, q, e);
    chk(n, x, q);
  endtask
  task automatic ptr(input logic [15:0] p);
    wr(OFS_PTR_LO, {24'h0, p[7:0]});
    wr(OFS_PTR_HI, {24'h0, p[15:8]});
  endtask
  task automatic buf_chk(input logic [5:0] i, input logic [15:0] x);
    idx <= i;
    repeat (2) @(posedge clk);
    #1 chk("buffer word", {16'h0, x}, {16'h0, bdat});
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      cpu.xfer(1'b0, OFS_CTRL, 32'h0, q, e);
      n++;
    end while (q[0] !== 1'b0 && n < 100);
    chk("idle wait", 32'h0, {31'h0, q[0]});
    @(posedge clk);
    #1;
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    print_verdict;
  end
  initial begin
    {rst, fuse, ee, idx} = {1'b1, 1'b1, 1'b0, 6'h0};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk("app vector", 32'h0, {17'h0, vec});
    rd(OFS_CTRL, {24'h0, CTRL_RESET}, "ctrl reset");
    rd(8'h20, 32'h0, "unmapped");
    chk("slave error", 32'h1, {31'h0, e});
    fuse <= 1'b0;
    wr(OFS_VECTOR, 32'h0);
    rd(OFS_VECTOR, {17'h0, BOOT_VECTOR}, "boot vector");
    fuse <= 1'b1;
    ptr(16'h0287);
    @(posedge clk);
    #1 chk("byte select", 32'h1, {31'h0, lhi});
    chk("load word", 32'h0143, {17'h0, lwa});
    wr(OFS_DATA, 32'h1234);
    cpu.spm(8'h01, 0);
    buf_chk(6'd3, 16'h1234);
    wr(OFS_DATA, 32'h5678);
    cpu.spm(8'h01, 0);
    buf_chk(6'd3, 16'h1234);
    buf_chk(6'd4, ERASED_WORD);
    for (int g = 2; g >= 1; g--) begin
      cpu.spm(8'h83, g);
      repeat (2) @(posedge clk);
      #1 chk("erase start", {31'h0, g == 1}, {31'h0, fer});
    end
    ptr(16'h7F00);
    chk("erase page", 32'h5, {23'h0, page});
    chk("rww halt", 32'h0, {31'h0, halt});
    chk("irq in op", 32'h0, {31'h0, irq});
    wait_idle;
    chk("ready irq", 32'h1, {31'h0, irq});
    rd(OFS_CTRL, 32'hC0, "ctrl after op");
    buf_chk(6'd3, 16'h1234);
    wr(OFS_CTRL, 32'h11);
    rd(OFS_CTRL, 32'h00, "ctrl reenabled");
    buf_chk(6'd3, ERASED_WORD);
    ptr(16'h7000);
    wr(OFS_DATA, 32'hABCD);
    cpu.spm(8'h01, 0);
    cpu.spm(8'h05, 0);
    repeat (2) @(posedge clk);
    #1 chk("write start", 32'h1, {31'h0, fwr & halt});
    chk("write page", 32'h0E0, {23'h0, page});
    wait_idle;
    buf_chk(6'd0, ERASED_WORD);
    wr(OFS_CTRL, 32'h11);
    wr(OFS_STORE, 32'h0);
    repeat (2) @(posedge clk);
    #1 chk("idle store", 32'h0, {31'h0, fer | fwr});
    ptr(16'h0002);
    cpu.spm(8'h01, 0);
    ee <= 1'b1;
    buf_chk(6'd1, ERASED_WORD);
    ee <= 1'b0;
    wr(OFS_DATA, 32'h00C3);
    cpu.spm(8'h09, 0);
    #1 chk("lock write", 32'h1, {31'h0, lkw});
    chk("lock data", 32'hC3, {24'h0, lkd});
    print_verdict;
  end
endmodule
bind flash_self_program_sequencer self_prog_checker #(.PROG_CYCLES(PROG_CYCLES)) sva_i (.*);
